//--- hdl/floppy_port_pkg.sv
package floppy_port_pkg;

  // Host port map
  localparam logic [9:0] DRIVE_CONTROL_ADDR = 10'h3F2;
  localparam logic [9:0] CTRL_STATUS_ADDR = 10'h3F4;
  localparam logic [9:0] CMD_RESULT_ADDR = 10'h3F5;
  localparam logic [7:0] DRIVE_CONTROL_RESET = 8'h00;
  localparam logic [7:0] IDLE_READ_VALUE = 8'h00;

  // Drive-control field positions
  localparam int SEL_LSB = 0;
  localparam int ENABLE_BIT = 2;
  localparam int GATE_BIT = 3;
  localparam int MOTOR_LSB = 4;
  localparam int NUM_UNITS = 4;

  // Status byte field positions
  localparam int ST_SEEK_LSB = 0;
  localparam int ST_BUSY_BIT = 4;
  localparam int ST_EXEC_BIT = 5;
  localparam int ST_DIR_BIT = 6;
  localparam int ST_READY_BIT = 7;

  // Stack depths
  localparam int CMD_DEPTH = 9;
  localparam int RES_DEPTH = 7;
  localparam int CMD_CNT_W = 4;
  localparam int RES_CNT_W = 3;

  // Timing: crystal reference and controller clock
  localparam int CORE_CLK_PERIOD_NS = 20;
  localparam int XTAL_FREQ_MHZ = 8;
  localparam int CTRL_CLK_PERIOD_NS = 250;
  localparam int CTRL_CLK_DIVIDE = (CTRL_CLK_PERIOD_NS * XTAL_FREQ_MHZ) / 1000;

  // Operation phases
  typedef enum logic [1:0] {
    PH_COMMAND,
    PH_EXECUTE,
    PH_RESULT
  } phase_type;

  // Host I/O request
  typedef struct packed {
    logic [9:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } io_req_type;

  // Port logic state
  typedef struct packed {
    logic [7:0] drive_control;
    phase_type phase;
    logic [7:0] rdata;
    logic rdata_en;
  } port_state_type;

endpackage

//--- hdl/ctrl_clk_divider.sv
`timescale 1ns/10ps
module ctrl_clk_divider
  import floppy_port_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic srst_i,
  // Crystal reference, sampled
  input wire logic xtal_i,
  // Divided controller clock
  output logic ctrl_clk_o
);

  typedef struct packed {
    logic xtal_prev;
    logic clk_out;
  } div_state_type;

  div_state_type state_reg;
  div_state_type state_next;

  // Toggle on each rising reference edge: divide by two
  always_comb begin
    state_next = state_reg;
    state_next.xtal_prev = xtal_i;
    if (xtal_i && !state_reg.xtal_prev) begin
      state_next.clk_out = !state_reg.clk_out;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign ctrl_clk_o = state_reg.clk_out;

  a_div_toggle: assert property (@(posedge core_clk_i) disable iff (srst_i)
    (xtal_i && !state_reg.xtal_prev) |=> (ctrl_clk_o != $past(ctrl_clk_o)))
    else $error("controller clock did not toggle on reference edge");
  a_div_hold: assert property (@(posedge core_clk_i) disable iff (srst_i)
    !(xtal_i && !state_reg.xtal_prev) |=> $stable(ctrl_clk_o))
    else $error("controller clock changed without reference edge");
  c_div_run: cover property (@(posedge core_clk_i) disable iff (srst_i) $rose(ctrl_clk_o));

endmodule

//--- hdl/byte_stack.sv
`timescale 1ns/10ps
module byte_stack
  import floppy_port_pkg::*;
#(
  parameter int DEPTH = 9,
  parameter int CNT_W = 4
)
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic srst_i,
  // Control
  input wire logic flush_i,
  input wire logic push_i,
  input wire logic [7:0] push_data_i,
  input wire logic pop_i,
  // Status
  output logic [7:0] top_o,
  output logic [CNT_W-1:0] count_o,
  output logic full_o,
  output logic empty_o
);

  localparam logic [CNT_W-1:0] FULL_COUNT = CNT_W'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][7:0] mem;
    logic [CNT_W-1:0] count;
  } stack_state_type;

  stack_state_type state_reg;
  stack_state_type state_next;
  logic do_pop;
  logic do_push;
  logic [CNT_W-1:0] wr_idx;

  // Oldest entry sits at index 0; a pop shifts all down
  always_comb begin
    state_next = state_reg;
    do_pop = pop_i && (state_reg.count != '0);
    do_push = push_i && ((state_reg.count != FULL_COUNT) || do_pop);
    wr_idx = do_pop ? state_reg.count - CNT_W'(1) : state_reg.count;
    if (do_pop) begin
      for (int i = 0; i < DEPTH - 1; i++) begin
        state_next.mem[i] = state_reg.mem[i + 1];
      end
    end
    if (do_push) begin
      state_next.mem[wr_idx] = push_data_i;
    end
    if (do_push && !do_pop) begin
      state_next.count = state_reg.count + CNT_W'(1);
    end else if (do_pop && !do_push) begin
      state_next.count = state_reg.count - CNT_W'(1);
    end
    if (flush_i) begin
      state_next.count = '0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign top_o = state_reg.mem[0];
  assign count_o = state_reg.count;
  assign full_o = (state_reg.count == FULL_COUNT);
  assign empty_o = (state_reg.count == '0);

endmodule

//--- hdl/floppy_host_port_logic.sv
`timescale 1ns/10ps
// Function
// - Drive-control at 3F2, write-only, no read
// - I/O reset clears drive-control to zero
// - Bits 4..7 drive motor outputs, units 0..3
// - Gate bit zero blocks interrupt and DMA
// - Controller runs only while enable bit set
// - Bits 1..0 pick exactly one drive select
// - Status byte readable at 3F4 any time
// - Status bit 0 shows unit 0 seeking
// - Data port 3F5, top stack entry visible
// - Host writes push, nine bytes at most
// - Host reads pop, seven results at most
// - Command, execution, result phases in order
// - Completion on interrupt six, records by DMA
// - Eight megahertz reference clocks the controller
// - Four drive units, own select and motor
// - Address bit 0 picks status or data
module floppy_host_port_logic
  import floppy_port_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic srst_i,
  // Host I/O bus
  input io_req_type io_req_i,
  output logic [7:0] io_rdata_o,
  output logic io_rdata_en_o,
  // Crystal reference and controller clock
  input wire logic xtal_i,
  output logic ctrl_clk_o,
  output logic ctrl_reset_o,
  // Controller core: command bytes
  output logic [7:0] cmd_byte_o,
  output logic cmd_valid_o,
  input wire logic cmd_pop_i,
  input wire logic cmd_complete_i,
  // Controller core: result bytes
  input wire logic [7:0] res_byte_i,
  input wire logic res_push_i,
  output logic res_ready_o,
  input wire logic exec_done_i,
  // Controller core: seek flags and requests
  input wire logic [NUM_UNITS-1:0] seek_busy_i,
  input wire logic ctrl_irq_i,
  input wire logic ctrl_drq_i,
  // I/O bus requests
  output logic irq6_o,
  output logic drq_o,
  // Drive cable
  output logic [NUM_UNITS-1:0] motor_on_o,
  output logic [NUM_UNITS-1:0] drive_sel_o,
  // Phase visibility
  output phase_type phase_o
);

  port_state_type state_reg;
  port_state_type state_next;

  logic ctrl_enabled;
  logic io_gate;
  logic pair_hit;
  logic port_select_bit;
  logic dc_write;
  logic dc_read;
  logic stat_read;
  logic data_read;
  logic data_write;
  logic cmd_push;
  logic cmd_flush;
  logic res_pop;
  logic res_push;
  logic res_flush;
  logic [7:0] status_byte;
  logic [7:0] cmd_top;
  logic [7:0] res_top;
  logic [CMD_CNT_W-1:0] cmd_count;
  logic [RES_CNT_W-1:0] res_count;
  logic cmd_full;
  logic cmd_empty;
  logic res_full;
  logic res_empty;

  // Full ten-bit match against one port address
  function automatic logic port_hit(input logic [9:0] addr, input logic [9:0] base);
    port_hit = (addr == base);
  endfunction

  // One-hot decode of the binary drive number
  function automatic logic [NUM_UNITS-1:0] unit_decode(input logic [1:0] num);
    unit_decode = NUM_UNITS'(1) << num;
  endfunction

  // Fields of the drive-control register
  assign ctrl_enabled = state_reg.drive_control[ENABLE_BIT];
  assign io_gate = state_reg.drive_control[GATE_BIT];

  // Address decode; the controller pair shares all bits but bit 0
  assign pair_hit = (io_req_i.addr[9:1] == CTRL_STATUS_ADDR[9:1]);
  assign port_select_bit = io_req_i.addr[0];
  assign dc_write = io_req_i.wr && port_hit(io_req_i.addr, DRIVE_CONTROL_ADDR);
  assign dc_read = io_req_i.rd && port_hit(io_req_i.addr, DRIVE_CONTROL_ADDR);
  assign stat_read = io_req_i.rd && pair_hit && !port_select_bit;
  assign data_read = io_req_i.rd && pair_hit && port_select_bit;
  assign data_write = io_req_i.wr && pair_hit && port_select_bit;

  // Stack strobes follow the current phase
  assign cmd_push = data_write && ctrl_enabled && (state_reg.phase == PH_COMMAND) && !cmd_full;
  assign res_pop = data_read && (state_reg.phase == PH_RESULT) && !res_empty;
  assign res_push = res_push_i && ctrl_enabled && (state_reg.phase == PH_EXECUTE);
  assign cmd_flush = !ctrl_enabled || ((state_reg.phase == PH_EXECUTE) && exec_done_i);
  assign res_flush = !ctrl_enabled;

  // Main status byte built from phase, stacks and seek flags
  always_comb begin
    status_byte = 8'h00;
    status_byte[ST_SEEK_LSB +: NUM_UNITS] = seek_busy_i;
    status_byte[ST_BUSY_BIT] = (state_reg.phase != PH_COMMAND) || !cmd_empty;
    status_byte[ST_EXEC_BIT] = (state_reg.phase == PH_EXECUTE);
    status_byte[ST_DIR_BIT] = (state_reg.phase == PH_RESULT);
    status_byte[ST_READY_BIT] = ctrl_enabled &&
      (((state_reg.phase == PH_COMMAND) && !cmd_full) || ((state_reg.phase == PH_RESULT) && !res_empty));
  end

  // Next state: drive-control register, phase sequencer and read answer
  always_comb begin
    state_next = state_reg;
    state_next.rdata = IDLE_READ_VALUE;
    state_next.rdata_en = 1'b0;
    if (dc_write) begin
      state_next.drive_control = io_req_i.wdata;
    end
    if (stat_read) begin
      state_next.rdata = status_byte;
      state_next.rdata_en = 1'b1;
    end else if (data_read) begin
      state_next.rdata = res_pop ? res_top : IDLE_READ_VALUE;
      state_next.rdata_en = 1'b1;
    end
    if (!ctrl_enabled) begin
      state_next.phase = PH_COMMAND;
    end else begin
      unique case (state_reg.phase)
        PH_COMMAND: begin
          if (cmd_complete_i) begin
            state_next.phase = PH_EXECUTE;
          end
        end
        PH_EXECUTE: begin
          if (exec_done_i) begin
            state_next.phase = PH_RESULT;
          end
        end
        PH_RESULT: begin
          if (res_empty || (res_pop && (res_count == RES_CNT_W'(1)))) begin
            state_next.phase = PH_COMMAND;
          end
        end
        default: begin
          state_next.phase = PH_COMMAND;
        end
      endcase
    end
  end

  // State register, cleared by the I/O reset
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      state_reg.drive_control <= DRIVE_CONTROL_RESET;
      state_reg.phase <= PH_COMMAND;
      state_reg.rdata <= IDLE_READ_VALUE;
      state_reg.rdata_en <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  // Command stack, filled by the host
  byte_stack #(
    .DEPTH(CMD_DEPTH),
    .CNT_W(CMD_CNT_W)
  ) u_cmd_stack (
    .core_clk_i(core_clk_i),
    .srst_i(srst_i),
    .flush_i(cmd_flush),
    .push_i(cmd_push),
    .push_data_i(io_req_i.wdata),
    .pop_i(cmd_pop_i && ctrl_enabled),
    .top_o(cmd_top),
    .count_o(cmd_count),
    .full_o(cmd_full),
    .empty_o(cmd_empty)
  );

  // Result stack, filled by the controller core
  byte_stack #(
    .DEPTH(RES_DEPTH),
    .CNT_W(RES_CNT_W)
  ) u_res_stack (
    .core_clk_i(core_clk_i),
    .srst_i(srst_i),
    .flush_i(res_flush),
    .push_i(res_push),
    .push_data_i(res_byte_i),
    .pop_i(res_pop),
    .top_o(res_top),
    .count_o(res_count),
    .full_o(res_full),
    .empty_o(res_empty)
  );

  // Controller clock from the crystal reference
  ctrl_clk_divider u_clk_div (
    .core_clk_i(core_clk_i),
    .srst_i(srst_i),
    .xtal_i(xtal_i),
    .ctrl_clk_o(ctrl_clk_o)
  );

  // Controller core side
  assign cmd_byte_o = cmd_top;
  assign cmd_valid_o = !cmd_empty && ctrl_enabled;
  assign res_ready_o = ctrl_enabled && (state_reg.phase == PH_EXECUTE) && !res_full;
  assign ctrl_reset_o = !ctrl_enabled;

  // Bus drivers for interrupt level six and DMA request
  assign irq6_o = ctrl_irq_i && io_gate && ctrl_enabled;
  assign drq_o = ctrl_drq_i && io_gate && ctrl_enabled;

  // Drive cable: one select and one motor per unit
  assign motor_on_o = state_reg.drive_control[MOTOR_LSB +: NUM_UNITS];
  assign drive_sel_o = unit_decode(state_reg.drive_control[SEL_LSB +: 2]);

  // Host read answer
  assign io_rdata_o = state_reg.rdata;
  assign io_rdata_en_o = state_reg.rdata_en;
  assign phase_o = state_reg.phase;

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (srst_i);

  // Checks on the drive-control register
  a_dc_reset_zero: assert property (disable iff (1'b0) srst_i |=> (motor_on_o == '0) && ctrl_reset_o)
    else $error("drive-control not cleared by reset");
  a_dc_no_read: assert property (dc_read |=> !io_rdata_en_o)
    else $error("drive-control port answered a read");
  a_motor_write: assert property (dc_write |=> motor_on_o == $past(io_req_i.wdata[7:4]))
    else $error("motor outputs do not follow written bits");
  a_sel_decode: assert property (dc_write |=> drive_sel_o == (4'h1 << $past(io_req_i.wdata[1:0])))
    else $error("drive select does not match written number");
  a_sel_onehot: assert property ($onehot(drive_sel_o))
    else $error("drive select not one-hot");
  a_gate_block: assert property ((dc_write && !io_req_i.wdata[3]) |=> (!irq6_o && !drq_o))
    else $error("interrupt or DMA passed with gate closed");
  a_enable_reset: assert property ((dc_write && !io_req_i.wdata[2]) |=> ctrl_reset_o && !cmd_valid_o)
    else $error("controller not held in reset while disabled");

  // Checks on the status and data ports
  a_status_read: assert property (stat_read |=> io_rdata_en_o && (io_rdata_o == $past(status_byte)))
    else $error("status read returned wrong byte");
  a_seek_unit0: assert property ((stat_read && seek_busy_i[0]) |=> io_rdata_o[0])
    else $error("unit 0 seek flag missing");
  a_data_pop: assert property (res_pop |=> io_rdata_en_o && (io_rdata_o == $past(res_top)))
    else $error("data read did not return top result");
  a_cmd_bound: assert property (cmd_count <= CMD_CNT_W'(CMD_DEPTH))
    else $error("command stack above nine bytes");
  a_cmd_full_drop: assert property ((cmd_full && data_write && !cmd_pop_i) |=> (cmd_count == $past(cmd_count)))
    else $error("write accepted into full command stack");
  a_res_bound: assert property (res_count <= RES_CNT_W'(RES_DEPTH))
    else $error("result stack above seven bytes");
  a_phase_order: assert property ((phase_o == PH_COMMAND) |=> (phase_o != PH_RESULT))
    else $error("result phase entered without execution");
  a_exec_done: assert property ((ctrl_enabled && (phase_o == PH_EXECUTE) && exec_done_i) |=> phase_o == PH_RESULT)
    else $error("execution end did not open result phase");

  // Checks on the host read answer
  a_read_idle: assert property (!(stat_read || data_read) |=> !io_rdata_en_o)
    else $error("read answer without a decoded read");
  a_write_silent: assert property ((io_req_i.wr && !io_req_i.rd) |=> !io_rdata_en_o)
    else $error("write cycle produced a read answer");
  a_idle_value: assert property (!io_rdata_en_o |-> (io_rdata_o == IDLE_READ_VALUE))
    else $error("read data not idle outside an answer");
  a_data_empty: assert property ((data_read && !res_pop) |=>
    io_rdata_en_o && (io_rdata_o == IDLE_READ_VALUE))
    else $error("data read without result not answered idle");
  a_seek_all: assert property (stat_read |=> (io_rdata_o[ST_SEEK_LSB +: NUM_UNITS] == $past(seek_busy_i)))
    else $error("status seek flags do not match the units");
  a_status_exec: assert property ((stat_read && (phase_o == PH_EXECUTE)) |=>
    io_rdata_o[ST_EXEC_BIT] && io_rdata_o[ST_BUSY_BIT] && !io_rdata_o[ST_READY_BIT])
    else $error("status byte does not show execution");
  a_status_result: assert property ((stat_read && (phase_o == PH_RESULT)) |=>
    io_rdata_o[ST_DIR_BIT] && io_rdata_o[ST_BUSY_BIT])
    else $error("status byte does not show result phase");

  // Drive-control outputs hold between writes; bus requests follow the gate
  a_motor_hold: assert property (!dc_write |=> $stable(motor_on_o))
    else $error("motor outputs changed without a write");
  a_sel_hold: assert property (!dc_write |=> $stable(drive_sel_o))
    else $error("drive select changed without a write");
  a_reset_follow: assert property (!ctrl_enabled |-> ctrl_reset_o)
    else $error("controller reset released while enable bit clear");
  a_irq_closed: assert property ((!io_gate || !ctrl_enabled) |-> (!irq6_o && !drq_o))
    else $error("bus request driven while gate or enable clear");
  a_irq_open: assert property ((io_gate && ctrl_enabled && ctrl_irq_i) |-> irq6_o)
    else $error("controller interrupt not routed to level six");
  a_drq_open: assert property ((io_gate && ctrl_enabled && ctrl_drq_i) |-> drq_o)
    else $error("controller DMA request not routed to the bus");

  // Phase sequencer and stack counts
  a_phase_disable: assert property (!ctrl_enabled |=> (phase_o == PH_COMMAND))
    else $error("phase left command while disabled");
  a_exec_entry: assert property ((ctrl_enabled && (phase_o == PH_COMMAND) && cmd_complete_i) |=>
    (phase_o == PH_EXECUTE))
    else $error("command end did not open execution phase");
  a_res_last: assert property ((res_pop && (res_count == RES_CNT_W'(1))) |=> (phase_o == PH_COMMAND))
    else $error("last result pop did not close the operation");
  a_cmd_grow: assert property ((cmd_push && !cmd_pop_i) |=>
    (cmd_count == $past(cmd_count) + CMD_CNT_W'(1)))
    else $error("accepted command byte not counted");
  a_cmd_refused: assert property ((data_write && (phase_o != PH_COMMAND)) |=>
    (cmd_count <= $past(cmd_count)))
    else $error("command byte accepted outside command phase");
  a_res_grow: assert property ((res_push && !res_full) |=>
    (res_count == $past(res_count) + RES_CNT_W'(1)))
    else $error("pushed result not counted");
  a_res_shrink: assert property ((res_pop && ctrl_enabled) |=>
    (res_count == $past(res_count) - RES_CNT_W'(1)))
    else $error("popped result not removed from the stack");

  // Main scenarios
  c_full_command: cover property (cmd_full ##[1:40] (phase_o == PH_EXECUTE));
  c_result_drain: cover property (res_pop ##2 res_pop ##2 res_pop ##1 (phase_o == PH_COMMAND));
  c_irq_out: cover property (irq6_o);
  c_unit0_seek: cover property (stat_read && (drive_sel_o == 4'h1) && seek_busy_i[0]);

endmodule

//--- bench/core_model.sv
`timescale 1ns/10ps
module core_model
  import floppy_port_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic srst_i,
  // Bench control
  input wire logic hold_i,
  input wire logic run_i,
  input wire logic [2:0] res_n_i,
  // Port logic side
  input wire logic [7:0] cmd_byte_i,
  input wire logic cmd_valid_i,
  input wire logic res_ready_i,
  output logic cmd_pop_o,
  output logic cmd_complete_o,
  output logic [7:0] res_byte_o,
  output logic res_push_o,
  output logic exec_done_o
);
  logic [7:0] got [0:15];
  int got_n;
  int st;
  int k;

  // Quiet outputs until the first clock edge
  initial begin
    cmd_pop_o = 1'b0;
    cmd_complete_o = 1'b0;
    res_byte_o = 8'h00;
    res_push_o = 1'b0;
    exec_done_o = 1'b0;
  end

  // Pops command bytes, then walks execution and result hand-off
  always @(posedge core_clk_i) begin
    cmd_pop_o <= 1'b0;
    cmd_complete_o <= 1'b0;
    res_push_o <= 1'b0;
    exec_done_o <= 1'b0;
    res_byte_o <= ~res_byte_o; // Stale data never looks valid
    if (srst_i) begin
      got_n <= 0;
      st <= 0;
    end else begin
      if (cmd_valid_i && !cmd_pop_o && !hold_i) begin
        cmd_pop_o <= 1'b1;
        got[got_n] <= cmd_byte_i;
        got_n <= got_n + 1;
      end
      case (st)
        0: if (run_i) begin
          cmd_complete_o <= 1'b1;
          k <= 0;
          st <= 1;
        end
        1: if (k == int'(res_n_i)) begin
          exec_done_o <= 1'b1;
          st <= 0;
        end else if (res_ready_i && !res_push_o) begin
          res_push_o <= 1'b1;
          res_byte_o <= 8'hC0 + 8'(k);
          k <= k + 1;
        end
        default: st <= 0;
      endcase
    end
  end
endmodule

//--- bench/floppy_host_port_logic_test.sv
`timescale 1ns/10ps
module floppy_host_port_logic_test;
  import floppy_port_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic xtal = 1'b0;
  io_req_type req = '0;
  logic [7:0] rdata, cmd_byte, res_byte, rd_v;
  logic rdata_en, ctrl_clk, ctrl_reset, cmd_valid, cmd_pop, cmd_complete, rd_e;
  logic res_push, res_ready, exec_done, irq6, drq;
  logic [3:0] seek = 4'h0;
  logic c_irq = 1'b0;
  logic c_drq = 1'b0;
  logic hold = 1'b0;
  logic run = 1'b0;
  logic [2:0] res_n = 3'h0;
  logic [3:0] motor, sel;
  phase_type phase;
  int fail_count = 0;
  int comparisons = 0;

  // Core clock and crystal reference
  initial forever #10 clk = ~clk;
  initial forever #62.5 xtal = ~xtal;

  floppy_host_port_logic i_dut (.core_clk_i(clk), .srst_i(srst), .io_req_i(req), .io_rdata_o(rdata),
    .io_rdata_en_o(rdata_en), .xtal_i(xtal), .ctrl_clk_o(ctrl_clk), .ctrl_reset_o(ctrl_reset),
    .cmd_byte_o(cmd_byte), .cmd_valid_o(cmd_valid), .cmd_pop_i(cmd_pop), .cmd_complete_i(cmd_complete),
    .res_byte_i(res_byte), .res_push_i(res_push), .res_ready_o(res_ready), .exec_done_i(exec_done),
    .seek_busy_i(seek), .ctrl_irq_i(c_irq), .ctrl_drq_i(c_drq), .irq6_o(irq6), .drq_o(drq),
    .motor_on_o(motor), .drive_sel_o(sel), .phase_o(phase));

  core_model i_core (.core_clk_i(clk), .srst_i(srst), .hold_i(hold), .run_i(run), .res_n_i(res_n),
    .cmd_byte_i(cmd_byte), .cmd_valid_i(cmd_valid), .res_ready_i(res_ready), .cmd_pop_o(cmd_pop),
    .cmd_complete_o(cmd_complete), .res_byte_o(res_byte), .res_push_o(res_push), .exec_done_o(exec_done));

  // Compare tasks and verdict
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_n(input int got, input int lo, input int hi, input string what);
    comparisons++;
    if (got < lo || got > hi) begin
      fail_count++;
      $display("[FAIL] %0t %s got %0d", $time, what, got);
    end
  endtask

  task automatic end_sim();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Host bus cycles, one strobe cycle each
  task automatic io_wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    req = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(posedge clk);
    #1;
    req.wr = 1'b0;
    req.wdata = ~d;
  endtask

  task automatic io_rd(input logic [9:0] a);
    @(posedge clk);
    #1;
    req = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h5A};
    @(posedge clk);
    #1;
    req.rd = 1'b0;
    rd_v = rdata;
    rd_e = rdata_en;
  endtask

  task automatic wait_phase(input phase_type p);
    for (int n = 0; n < 100; n++) begin
      if (phase === p) return;
      @(posedge clk);
      #1;
    end
    chk({6'h00, phase}, {6'h00, p}, "phase wait");
  endtask

  task automatic drain();
    for (int n = 0; n < 30 && cmd_valid !== 1'b0; n++) begin
      @(posedge clk);
      #1;
    end
  endtask

  // Reset state and the write-only port
  task automatic t_reset();
    chk({4'h0, motor}, 8'h00, "motor reset");
    chk({4'h0, sel}, 8'h01, "select reset");
    chk({6'h00, ctrl_reset, irq6}, 8'h02, "ctl reset");
    io_rd(10'h3F2);
    chk({7'h00, rd_e}, 8'h00, "dor read");
  endtask

  // Drive select, motors, gating and enable
  task automatic t_drive();
    for (int s = 0; s < 4; s++) begin
      io_wr(10'h3F2, {4'h1 << s, 2'b01, 2'(s)});
      chk({4'h0, motor}, 8'(4'h1 << s), "motor");
      chk({4'h0, sel}, 8'(4'h1 << s), "select");
      chk({7'h00, ctrl_reset}, 8'h00, "ctl run");
    end
    c_irq = 1'b1;
    c_drq = 1'b1;
    #1;
    chk({6'h00, irq6, drq}, 8'h00, "gate off");
    io_wr(10'h3F2, 8'h0C);
    chk({6'h00, irq6, drq}, 8'h03, "gate on");
    io_wr(10'h3F2, 8'h08);
    chk({6'h00, irq6, drq}, 8'h00, "enable off");
    c_irq = 1'b0;
    c_drq = 1'b0;
  endtask

  // Status byte and port select bit
  task automatic t_status();
    io_wr(10'h3F2, 8'h04);
    seek = 4'h5;
    io_rd(10'h3F4);
    chk({7'h00, rd_e}, 8'h01, "status en");
    chk(rd_v, 8'h85, "status");
    io_rd(10'h3F5);
    chk({rd_v[6:0], rd_e}, 8'h01, "idle data");
    seek = 4'h0;
  endtask

  // Full command, execution, result walk
  task automatic t_operation();
    int b;
    b = i_core.got_n;
    for (int i = 0; i < 3; i++) io_wr(10'h3F5, 8'h40 + 8'(i));
    drain();
    for (int i = 0; i < 3; i++) chk(i_core.got[b + i], 8'h40 + 8'(i), "cmd byte");
    res_n = 3'd7;
    run = 1'b1;
    @(posedge clk);
    #1;
    run = 1'b0;
    wait_phase(PH_EXECUTE);
    io_rd(10'h3F4);
    chk(rd_v, 8'h30, "exec status");
    io_wr(10'h3F5, 8'h99);
    wait_phase(PH_RESULT);
    io_rd(10'h3F4);
    chk(rd_v, 8'hD0, "result status");
    for (int i = 0; i < 7; i++) begin
      io_rd(10'h3F5);
      chk(rd_v, 8'hC0 + 8'(i), "result");
    end
    chk({6'h00, phase}, {6'h00, PH_COMMAND}, "back to command");
    io_rd(10'h3F5);
    chk(rd_v, 8'h00, "eighth result");
    chk_n(i_core.got_n - b, 3, 3, "cmd refused");
  endtask

  // Nine-byte limit with a stalled core, then empty result
  task automatic t_overflow();
    int b;
    b = i_core.got_n;
    hold = 1'b1;
    for (int i = 0; i < 10; i++) io_wr(10'h3F5, 8'h10 + 8'(i));
    io_rd(10'h3F4);
    chk(rd_v, 8'h10, "full status");
    hold = 1'b0;
    drain();
    chk_n(i_core.got_n - b, 9, 9, "cmd count");
    for (int i = 0; i < 9; i++) chk(i_core.got[b + i], 8'h10 + 8'(i), "kept byte");
    res_n = 3'd0;
    run = 1'b1;
    @(posedge clk);
    #1;
    run = 1'b0;
    wait_phase(PH_EXECUTE);
    wait_phase(PH_RESULT);
    wait_phase(PH_COMMAND);
  endtask

  // Disabled controller drops bytes; divided clock rate
  task automatic t_disable_clock();
    int t;
    logic last;
    io_wr(10'h3F2, 8'h00);
    io_wr(10'h3F5, 8'h77);
    chk({6'h00, cmd_valid, ctrl_reset}, 8'h01, "disabled");
    t = 0;
    last = ctrl_clk;
    repeat (100) begin
      @(posedge clk);
      #1;
      if (ctrl_clk !== last) t++;
      last = ctrl_clk;
    end
    chk_n(t, 15, 17, "ctl clock");
  endtask

  // Main sequence
  initial begin
    repeat (10) @(posedge clk);
    #1;
    srst = 1'b0;
    t_reset();
    t_drive();
    t_status();
    t_operation();
    t_overflow();
    t_disable_clock();
    end_sim();
  end

  // Watchdog against a hang
  initial begin
    #200000;
    fail_count++;
    end_sim();
  end
endmodule
